// ---- rtl/gpe_enable_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpe_enable_reg (
    input wire logic clk,
    input wire logic rst,
    input wire logic resume_rst,
    input wire logic clock_rst,
    input wire logic override_clr,
    gpe_if.enables bus
);
    logic [15:0] enable_d;

    // clears take priority over a same-cycle write; reserved bits never store
    always_comb begin
        enable_d = bus.enable_q;
        if (bus.enable_wr) begin
            enable_d = bus.wdata & gpe_pkg::ENABLE_WRITABLE;
        end
        if (resume_rst) begin
            enable_d = enable_d & ~gpe_pkg::RESUME_WELL_MASK;
        end
        if (clock_rst) begin
            enable_d = enable_d & ~gpe_pkg::CLOCK_WELL_MASK;
        end
        if (override_clr) begin
            enable_d = gpe_pkg::ENABLE_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.enable_q <= gpe_pkg::ENABLE_RESET;
        end else begin
            bus.enable_q <= enable_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ring_keeps_resume;
        resume_rst && !clock_rst && !override_clr && !bus.enable_wr |=>
            bus.enable_q[gpe_pkg::BIT_RING_EN] == $past(bus.enable_q[gpe_pkg::BIT_RING_EN]);
    endproperty
    a_ring_keeps_resume: assert property (p_ring_keeps_resume)
        else $error("ring enable changed on resume-well reset");

    property p_reserved_zero;
        (bus.enable_q & ~gpe_pkg::ENABLE_WRITABLE) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved enable bit set");

    property p_override_clears;
        override_clr |=> bus.enable_q == 16'h0000;
    endproperty
    a_override_clears: assert property (p_override_clears)
        else $error("override did not clear enables");
endmodule : gpe_enable_reg
`default_nettype wire

// ---- rtl/gpe_event_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpe_event_gate #(
    parameter logic [15:0] GPI_IMPL = gpe_pkg::GPI_IMPL_DEFAULT
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic RESUME_WELL_RESET,
    input wire logic CLOCK_WELL_RESET,
    input wire logic POWER_BUTTON_OVERRIDE,
    input wire logic [15:0] POWER_MGMT_IO_BASE,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [15:0] IO_WDATA,
    output logic [15:0] IO_RDATA,
    output logic IO_RDATA_VALID,
    input wire logic [2:0] SLEEP_STATE,
    input wire logic S5_BY_OVERRIDE,
    input wire logic ACPI_MODE,
    input wire logic POWER_MGMT_WAKE_STATUS,
    input wire logic RING_INDICATE_INPUT_N,
    input wire logic MGMT_BUS_WAKE_REQ,
    input wire logic WATCHDOG_SCI_STATUS,
    input wire logic [1:0] CODEC_SDATA_IN,
    input wire logic CODEC_BITCLK_IDLE,
    input wire logic CODEC_INT_FLAG,
    input wire logic USB_WAKE_STATUS,
    input wire logic THERMAL_ALERT_INPUT,
    input wire logic [15:0] GPI_PIN,
    input wire logic [15:0] GPI_IS_INPUT,
    input wire logic [15:0] INPUT_INVERT_SELECT,
    input wire logic [15:0] GENERAL_INPUT_EVENT_ENABLE,
    input wire logic [31:0] INPUT_EVENT_ROUTING,
    output logic WAKE_EVENT,
    output logic SCI_REQ,
    output logic SYSTEM_MGMT_INTERRUPT
);
    gpe_if gbus ();

    logic [15:0] ev0_status_q;
    logic [15:0] ev0_status_d;
    logic ring_in_q;
    logic thermal_active;
    logic sleeping;
    logic pme_wake_ok;
    logic gpi_smi;
    logic gpi_sci;
    logic wake_d;
    logic sci_d;
    logic smi_d;
    logic [15:0] gpi_pending;

    // address match against the relocatable power-management base
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] base, input logic [15:0] ofs);
        hit = (addr == 16'(base + ofs)); // base near the top of i/o space wraps, carry dropped on purpose
    endfunction : hit

    assign gbus.wdata = IO_WDATA;
    assign gbus.enable_wr = IO_WR && hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_EVENT0_WAKE_ENABLE);
    assign gbus.status_w1c = IO_WR && hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_INPUT_EVENT_STATUS);

    // per-pin active level: low by default, high when inverted
    for (genvar i = 0; i < gpe_pkg::GPI_COUNT; i++) begin : g_gpi
        assign gbus.gpi_active[i] = GPI_IS_INPUT[i] && (INPUT_INVERT_SELECT[i] ? GPI_PIN[i] : !GPI_PIN[i]);
    end

    gpe_enable_reg u_enable (
        .clk(CLOCK),
        .rst(SYS_RST),
        .resume_rst(RESUME_WELL_RESET),
        .clock_rst(CLOCK_WELL_RESET),
        .override_clr(POWER_BUTTON_OVERRIDE),
        .bus(gbus)
    );

    gpe_input_status #(
        .GPI_IMPL(GPI_IMPL)
    ) u_status (
        .clk(CLOCK),
        .rst(SYS_RST),
        .resume_rst(RESUME_WELL_RESET),
        .bus(gbus)
    );

    // thermal polarity select decides which pin level counts as active
    assign thermal_active = gbus.enable_q[gpe_pkg::BIT_THERM_POL] ? THERMAL_ALERT_INPUT
                                                                  : !THERMAL_ALERT_INPUT;

    // previous ring level, for the falling-edge detect
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ring_in_q <= 1'b1;
        end else begin
            ring_in_q <= RING_INDICATE_INPUT_N;
        end
    end

    // locally held event-0 status: set wins over a same-cycle write-one clear
    always_comb begin
        ev0_status_d = ev0_status_q;
        if (IO_WR && hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_EVENT0_STATUS)) begin
            ev0_status_d[gpe_pkg::STS_RING] = ev0_status_q[gpe_pkg::STS_RING] && !IO_WDATA[gpe_pkg::STS_RING];
            ev0_status_d[gpe_pkg::STS_CODEC] = ev0_status_q[gpe_pkg::STS_CODEC] && !IO_WDATA[gpe_pkg::STS_CODEC];
            ev0_status_d[gpe_pkg::STS_THERMAL] = ev0_status_q[gpe_pkg::STS_THERMAL]
                                                 && !IO_WDATA[gpe_pkg::STS_THERMAL];
        end
        if (ring_in_q && !RING_INDICATE_INPUT_N) begin
            ev0_status_d[gpe_pkg::STS_RING] = 1'b1;
        end
        if (((|CODEC_SDATA_IN) && CODEC_BITCLK_IDLE) || CODEC_INT_FLAG) begin
            ev0_status_d[gpe_pkg::STS_CODEC] = 1'b1;
        end
        // resume reset clears thermal only; ring and codec survive well resets
        if (RESUME_WELL_RESET) begin
            ev0_status_d[gpe_pkg::STS_THERMAL] = 1'b0;
        end
        if (thermal_active) begin
            ev0_status_d[gpe_pkg::STS_THERMAL] = 1'b1;
        end
    end

    // of the resets, only SYS_RST (full power loss of the backed well) clears ring and codec status; a write-one clear also clears them
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ev0_status_q <= gpe_pkg::EVENT0_STATUS_RESET;
        end else begin
            ev0_status_q <= ev0_status_d;
        end
    end

    // general input routing, one 2-bit field per input
    always_comb begin
        gpi_smi = 1'b0;
        gpi_sci = 1'b0;
        gpi_pending = gbus.status_q & GENERAL_INPUT_EVENT_ENABLE;
        for (int i = 0; i < gpe_pkg::GPI_COUNT; i++) begin
            if (gpi_pending[i]) begin
                unique case (gpe_pkg::gpe_route_t'(INPUT_EVENT_ROUTING[2*i +: 2]))
                    gpe_pkg::ROUTE_SMI: gpi_smi = 1'b1;
                    gpe_pkg::ROUTE_SCI: gpi_sci = 1'b1;
                    gpe_pkg::ROUTE_NONE, gpe_pkg::ROUTE_RSVD: ;
                endcase
            end
        end
    end

    assign sleeping = (SLEEP_STATE != gpe_pkg::SLEEP_S0);
    // from S5 the power-management wake counts only if S5 came from a software sleep entry
    assign pme_wake_ok = !((SLEEP_STATE == gpe_pkg::SLEEP_S5) && S5_BY_OVERRIDE);

    // wake gating: each source needs its status and its enable
    always_comb begin
        wake_d = 1'b0;
        if (sleeping) begin
            wake_d = (POWER_MGMT_WAKE_STATUS && gbus.enable_q[gpe_pkg::BIT_PM_WAKE_EN] && pme_wake_ok)
                  || (ev0_status_q[gpe_pkg::STS_RING] && gbus.enable_q[gpe_pkg::BIT_RING_EN])
                  || (MGMT_BUS_WAKE_REQ && gbus.enable_q[gpe_pkg::BIT_MGMT_BUS_EN])
                  || (ev0_status_q[gpe_pkg::STS_CODEC] && gbus.enable_q[gpe_pkg::BIT_CODEC_EN])
                  || (USB_WAKE_STATUS && gbus.enable_q[gpe_pkg::BIT_USB_EN])
                  || (gpi_pending != 16'h0000);
        end
    end

    // working-state interrupts; thermal goes to SCI under ACPI, else to SMI
    always_comb begin
        sci_d = 1'b0;
        smi_d = 1'b0;
        if (!sleeping) begin
            sci_d = (POWER_MGMT_WAKE_STATUS && gbus.enable_q[gpe_pkg::BIT_PM_WAKE_EN])
                 || (WATCHDOG_SCI_STATUS && gbus.enable_q[gpe_pkg::BIT_WDOG_SCI_EN])
                 || (ev0_status_q[gpe_pkg::STS_THERMAL] && gbus.enable_q[gpe_pkg::BIT_THERM_EN] && ACPI_MODE)
                 || gpi_sci;
            smi_d = (ev0_status_q[gpe_pkg::STS_THERMAL] && gbus.enable_q[gpe_pkg::BIT_THERM_EN] && !ACPI_MODE)
                 || gpi_smi;
        end
    end

    // event outputs registered so the ports come straight from flops
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WAKE_EVENT <= 1'b0;
            SCI_REQ <= 1'b0;
            SYSTEM_MGMT_INTERRUPT <= 1'b0;
        end else begin
            WAKE_EVENT <= wake_d;
            SCI_REQ <= sci_d;
            SYSTEM_MGMT_INTERRUPT <= smi_d;
        end
    end

    // read port: one cycle latency, unmapped addresses return zero
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            IO_RDATA <= 16'h0000;
            IO_RDATA_VALID <= 1'b0;
        end else begin
            IO_RDATA_VALID <= IO_RD;
            if (!IO_RD) begin
                IO_RDATA <= 16'h0000;
            end else if (hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_EVENT0_WAKE_ENABLE)) begin
                IO_RDATA <= gbus.enable_q;
            end else if (hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_INPUT_EVENT_STATUS)) begin
                IO_RDATA <= gbus.status_q;
            end else if (hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_EVENT0_STATUS)) begin
                IO_RDATA <= ev0_status_q;
            end else begin
                IO_RDATA <= 16'h0000;
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    sequence s_ring_enable_off;
        !gbus.enable_q[gpe_pkg::BIT_RING_EN] && !MGMT_BUS_WAKE_REQ && !USB_WAKE_STATUS
            && !POWER_MGMT_WAKE_STATUS && !ev0_status_q[gpe_pkg::STS_CODEC] && gpi_pending == 16'h0000;
    endsequence

    property p_ring_no_wake;
        s_ring_enable_off |=> !WAKE_EVENT;
    endproperty
    a_ring_no_wake: assert property (p_ring_no_wake)
        else $error("wake without any enabled source");

    property p_ring_wake;
        sleeping && ev0_status_q[gpe_pkg::STS_RING] && gbus.enable_q[gpe_pkg::BIT_RING_EN] |=> WAKE_EVENT;
    endproperty
    a_ring_wake: assert property (p_ring_wake)
        else $error("enabled ring status did not wake");

    property p_codec_wake;
        sleeping && ev0_status_q[gpe_pkg::STS_CODEC] && gbus.enable_q[gpe_pkg::BIT_CODEC_EN] |=> WAKE_EVENT;
    endproperty
    a_codec_wake: assert property (p_codec_wake)
        else $error("enabled codec status did not wake");

    property p_wdog_sci;
        !sleeping && WATCHDOG_SCI_STATUS && gbus.enable_q[gpe_pkg::BIT_WDOG_SCI_EN] |=> SCI_REQ;
    endproperty
    a_wdog_sci: assert property (p_wdog_sci)
        else $error("watchdog sci missing");

    property p_pme_s5_override;
        (SLEEP_STATE == gpe_pkg::SLEEP_S5) && S5_BY_OVERRIDE && !gbus.enable_q[gpe_pkg::BIT_RING_EN]
            && !gbus.enable_q[gpe_pkg::BIT_MGMT_BUS_EN] && !gbus.enable_q[gpe_pkg::BIT_CODEC_EN]
            && !gbus.enable_q[gpe_pkg::BIT_USB_EN] && gpi_pending == 16'h0000 |=> !WAKE_EVENT;
    endproperty
    a_pme_s5_override: assert property (p_pme_s5_override)
        else $error("wake from override-entered S5");

    sequence s_thermal_active;
        thermal_active && !RESUME_WELL_RESET;
    endsequence

    property p_thermal_sets;
        s_thermal_active ##1 1'b1 |-> ev0_status_q[gpe_pkg::STS_THERMAL] ##1 1'b1;
    endproperty
    a_thermal_sets: assert property (p_thermal_sets)
        else $error("active thermal input did not set status");

    property p_gpi_sleep_wake;
        sleeping && gpi_pending != 16'h0000 |=> WAKE_EVENT;
    endproperty
    a_gpi_sleep_wake: assert property (p_gpi_sleep_wake)
        else $error("enabled input status did not wake");

    property p_read_latency;
        IO_RD && hit(IO_ADDR, POWER_MGMT_IO_BASE, gpe_pkg::OFS_EVENT0_WAKE_ENABLE) |=>
            IO_RDATA_VALID && IO_RDATA == $past(gbus.enable_q);
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("enable read returned wrong data");
endmodule : gpe_event_gate
`default_nettype wire

// ---- rtl/gpe_input_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpe_input_status #(
    parameter logic [15:0] GPI_IMPL = gpe_pkg::GPI_IMPL_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic resume_rst,
    gpe_if.status bus
);
    logic [15:0] status_d;

    // set wins over clear; a w1c on a still-active input leaves the bit set
    always_comb begin
        status_d = bus.status_q;
        if (bus.status_w1c) begin
            status_d = status_d & ~(bus.wdata & ~bus.gpi_active);
        end
        status_d = (status_d | bus.gpi_active) & GPI_IMPL;
        if (resume_rst) begin
            status_d = gpe_pkg::STATUS_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.status_q <= gpe_pkg::STATUS_RESET;
        end else begin
            bus.status_q <= status_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_active_sets;
        !resume_rst && (bus.gpi_active != 16'h0000) |=>
            (bus.status_q & $past(bus.gpi_active) & GPI_IMPL) == ($past(bus.gpi_active) & GPI_IMPL);
    endproperty
    a_active_sets: assert property (p_active_sets)
        else $error("active input did not set status");

    property p_unimpl_zero;
        (bus.status_q & ~GPI_IMPL) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented status bit set");
endmodule : gpe_input_status
`default_nettype wire

// ---- shared/gpe_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface gpe_if;
    logic [15:0] wdata;
    logic enable_wr;
    logic status_w1c;
    logic [15:0] gpi_active;
    logic [15:0] enable_q;
    logic [15:0] status_q;
    modport ctrl (output wdata, output enable_wr, output status_w1c, output gpi_active,
                  input enable_q, input status_q);
    modport enables (input wdata, input enable_wr, output enable_q);
    modport status (input wdata, input status_w1c, input gpi_active, output status_q);
endinterface : gpe_if
`default_nettype wire

// ---- shared/gpe_pkg.sv ----
`default_nettype none
package gpe_pkg;
    // i/o offsets relative to the power-management base
    localparam logic [15:0] OFS_EVENT0_STATUS = 16'h0028;
    localparam logic [15:0] OFS_EVENT0_WAKE_ENABLE = 16'h002A;
    localparam logic [15:0] OFS_INPUT_EVENT_STATUS = 16'h002C;
    // reset values
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] EVENT0_STATUS_RESET = 16'h0000;
    // writable enable bits: 11, 8, 7, 6, 5, 3, 2, 0
    localparam logic [15:0] ENABLE_WRITABLE = 16'h09ED;
    // bits cleared by each well reset
    localparam logic [15:0] RESUME_WELL_MASK = 16'h08FF;
    localparam logic [15:0] CLOCK_WELL_MASK = 16'hFF00;
    // enable field positions
    localparam int BIT_PM_WAKE_EN = 11;
    localparam int BIT_RING_EN = 8;
    localparam int BIT_MGMT_BUS_EN = 7;
    localparam int BIT_WDOG_SCI_EN = 6;
    localparam int BIT_CODEC_EN = 5;
    localparam int BIT_USB_EN = 3;
    localparam int BIT_THERM_POL = 2;
    localparam int BIT_THERM_EN = 0;
    // locally held event-0 status positions
    localparam int STS_RING = 8;
    localparam int STS_CODEC = 5;
    localparam int STS_THERMAL = 0;
    localparam int GPI_COUNT = 16;
    localparam logic [15:0] GPI_IMPL_DEFAULT = 16'hFFFF;
    // sleep state encoding on the sleep-state input
    localparam logic [2:0] SLEEP_S0 = 3'h0;
    localparam logic [2:0] SLEEP_S5 = 3'h5;
    // per-input routing field
    typedef enum logic [1:0] {ROUTE_NONE, ROUTE_SMI, ROUTE_SCI, ROUTE_RSVD} gpe_route_t;
endpackage : gpe_pkg
`default_nettype wire

// ---- tb/gpe_sleep_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// sleep sequencer stand-in: follows the requested state, resumes to s0 after a wake
module gpe_sleep_partner #(
    parameter int DELAY = 3
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [2:0] req_state,
    input wire logic req_override,
    input wire logic auto_resume,
    input wire logic WAKE_EVENT,
    output logic [2:0] SLEEP_STATE,
    output logic S5_BY_OVERRIDE
);
    logic [2:0] last_q;
    logic woke_q;
    int cnt_q;
    // counts wake cycles; a slow delay models a sluggish power sequencer
    always @(negedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            last_q <= 3'h0;
            woke_q <= 1'b0;
            cnt_q <= 0;
        end else if (req_state != last_q) begin
            last_q <= req_state;
            woke_q <= 1'b0;
            cnt_q <= 0;
        end else if (auto_resume && WAKE_EVENT === 1'b1 && !woke_q) begin
            cnt_q <= cnt_q + 1;
            woke_q <= (cnt_q + 1 >= DELAY);
        end
    end
    // override entry only flagged in s5, where it blocks the power-management wake
    assign SLEEP_STATE = woke_q ? gpe_pkg::SLEEP_S0 : last_q;
    assign S5_BY_OVERRIDE = (last_q == gpe_pkg::SLEEP_S5) && req_override;
endmodule : gpe_sleep_partner
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [15:0] BASE = 16'h0400;
    logic CLOCK = 0, SYS_RST = 1, RESUME_WELL_RESET = 0, CLOCK_WELL_RESET = 0, POWER_BUTTON_OVERRIDE = 0;
    logic [15:0] IO_ADDR = 16'h0000, IO_WDATA = 16'h0000, GPI_PIN = 16'hFFFF, GPI_IS_INPUT = 16'hFFFF;
    logic [15:0] INPUT_INVERT_SELECT = 16'h0000, GENERAL_INPUT_EVENT_ENABLE = 16'h0000, IO_RDATA;
    logic IO_WR = 0, IO_RD = 0, ACPI_MODE = 1, POWER_MGMT_WAKE_STATUS = 0, RING_INDICATE_INPUT_N = 1;
    logic MGMT_BUS_WAKE_REQ = 0, WATCHDOG_SCI_STATUS = 0, CODEC_INT_FLAG = 0, USB_WAKE_STATUS = 0;
    logic THERMAL_ALERT_INPUT = 1, IO_RDATA_VALID, WAKE_EVENT, SCI_REQ, SYSTEM_MGMT_INTERRUPT, S5_BY_OVERRIDE;
    logic [31:0] INPUT_EVENT_ROUTING = 32'h00000000, lfsr_q = 32'h00010D76;
    logic [2:0] SLEEP_STATE, req_state = 3'h0;
    logic req_override = 0, auto_resume = 0, CODEC_BITCLK_IDLE = 1;
    logic [1:0] CODEC_SDATA_IN = 2'h0;
    int miscompares = 0, num_checks = 0;
    int en_bit[6] = '{11, 8, 7, 5, 3, 6};
    logic [15:0] exp_q[$];

    always #2 CLOCK = ~CLOCK;

    gpe_event_gate uut (.CLOCK, .SYS_RST, .RESUME_WELL_RESET, .CLOCK_WELL_RESET, .POWER_BUTTON_OVERRIDE,
        .POWER_MGMT_IO_BASE(BASE), .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA, .IO_RDATA_VALID,
        .SLEEP_STATE, .S5_BY_OVERRIDE, .ACPI_MODE, .POWER_MGMT_WAKE_STATUS, .RING_INDICATE_INPUT_N,
        .MGMT_BUS_WAKE_REQ, .WATCHDOG_SCI_STATUS, .CODEC_SDATA_IN, .CODEC_BITCLK_IDLE,
        .CODEC_INT_FLAG, .USB_WAKE_STATUS, .THERMAL_ALERT_INPUT, .GPI_PIN, .GPI_IS_INPUT,
        .INPUT_INVERT_SELECT, .GENERAL_INPUT_EVENT_ENABLE, .INPUT_EVENT_ROUTING, .WAKE_EVENT, .SCI_REQ,
        .SYSTEM_MGMT_INTERRUPT);

    gpe_sleep_partner #(.DELAY(3)) sleeper (.CLOCK, .SYS_RST, .req_state, .req_override, .auto_resume,
        .WAKE_EVENT, .SLEEP_STATE, .S5_BY_OVERRIDE);

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[15:0];
    endfunction : rnd

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic waitn(input int n);
        repeat (n) @(negedge CLOCK);
    endtask : waitn

    task automatic wr(input logic [15:0] ofs, input logic [15:0] d);
        @(negedge CLOCK);
        IO_ADDR = BASE + ofs;
        IO_WDATA = d;
        IO_WR = 1;
        @(negedge CLOCK);
        IO_WR = 0;
    endtask : wr

    // expected read word is noted here and compared by the watcher below
    task automatic rd(input logic [15:0] ofs, input logic [15:0] e);
        @(negedge CLOCK);
        IO_ADDR = BASE + ofs;
        IO_RD = 1;
        exp_q.push_back(e);
        @(negedge CLOCK);
        IO_RD = 0;
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge CLOCK);
        s = 1;
        @(negedge CLOCK);
        s = 0;
    endtask : pulse

    task automatic src(input int i, input logic v);
        case (i)
            0: POWER_MGMT_WAKE_STATUS = v;
            1: RING_INDICATE_INPUT_N = ~v;
            2: MGMT_BUS_WAKE_REQ = v;
            3: CODEC_INT_FLAG = v;
            4: USB_WAKE_STATUS = v;
            default: WATCHDOG_SCI_STATUS = v;
        endcase
    endtask : src

    // read watcher: oldest note against each returned word
    always @(negedge CLOCK) begin
        if (IO_RDATA_VALID === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", IO_RDATA, 16'hDEAD);
            else check("read data", IO_RDATA, exp_q.pop_front());
        end
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #40000;
        miscompares++;
        final_report();
    end

    initial begin
        waitn(2);
        SYS_RST = 0;
        rd(16'h002A, 16'h0000);
        rd(16'h002C, 16'h0000);
        wr(16'h002A, 16'hFFFF);
        rd(16'h002A, 16'h09ED);
        rd(16'h0030, 16'h0000);
        pulse(RESUME_WELL_RESET);
        rd(16'h002A, 16'h0100);
        wr(16'h002A, 16'hFFFF);
        pulse(CLOCK_WELL_RESET);
        rd(16'h002A, 16'h00ED);
        wr(16'h002A, 16'hFFFF);
        pulse(POWER_BUTTON_OVERRIDE);
        rd(16'h002A, 16'h0000);
        $display("register test done");
        // active inputs must survive the clear, inactive ones must go
        for (int k = 0; k < 4; k++) begin
            INPUT_INVERT_SELECT = rnd();
            GPI_IS_INPUT = rnd();
            GPI_PIN = rnd();
            waitn(2);
            wr(16'h002C, 16'hFFFF);
            rd(16'h002C, ~(GPI_PIN ^ INPUT_INVERT_SELECT) & GPI_IS_INPUT);
        end
        GPI_PIN = ~INPUT_INVERT_SELECT;
        waitn(2);
        wr(16'h002C, 16'hFFFF);
        rd(16'h002C, 16'h0000);
        $display("input status test done");
        // input 3 routed to sci, input 4 to smi; wake from s3 then resume
        GPI_IS_INPUT = 16'hFFFF;
        INPUT_INVERT_SELECT = 16'h0000;
        GPI_PIN = 16'hFFFF;
        GENERAL_INPUT_EVENT_ENABLE = 16'h0018;
        INPUT_EVENT_ROUTING = 32'h00000180;
        req_state = 3'h3;
        auto_resume = 1;
        wr(16'h002C, 16'hFFFF);
        GPI_PIN[3] = 0;
        waitn(2);
        check("wake", WAKE_EVENT, 16'h0001);
        waitn(6);
        check("sci", SCI_REQ, 16'h0001);
        GPI_PIN[4] = 0;
        waitn(3);
        check("smi", SYSTEM_MGMT_INTERRUPT, 16'h0001);
        auto_resume = 0;
        req_state = 3'h0;
        GPI_PIN = 16'hFFFF;
        GENERAL_INPUT_EVENT_ENABLE = 16'h0000;
        wr(16'h002C, 16'hFFFF);
        $display("input event test done");
        // thermal input under each polarity, sci then smi
        for (int p = 0; p < 2; p++) begin
            THERMAL_ALERT_INPUT = ~p[0];
            wr(16'h002A, 16'h0001 | (16'(p) << 2));
            wr(16'h0028, 16'hFFFF);
            waitn(3);
            check("thermal idle", SCI_REQ, 16'h0000);
            THERMAL_ALERT_INPUT = p[0];
            waitn(3);
            check("thermal sci", SCI_REQ, 16'h0001);
            ACPI_MODE = 0;
            waitn(2);
            check("thermal smi", SYSTEM_MGMT_INTERRUPT, 16'h0001);
            ACPI_MODE = 1;
            THERMAL_ALERT_INPUT = ~p[0];
        end
        wr(16'h002A, 16'h0004);
        wr(16'h0028, 16'hFFFF);
        $display("thermal test done");
        // each source gated by its own enable bit
        for (int i = 0; i < 6; i++) begin
            req_state = (i == 5) ? 3'h0 : 3'h3;
            src(i, 1);
            waitn(3);
            check("gated off", (i == 5) ? SCI_REQ : WAKE_EVENT, 16'h0000);
            wr(16'h002A, 16'h0004 | (16'h0001 << en_bit[i]));
            waitn(3);
            check("gated on", (i == 5) ? SCI_REQ : WAKE_EVENT, 16'h0001);
            src(i, 0);
            wr(16'h002A, 16'h0004);
            wr(16'h0028, 16'hFFFF);
        end
        // s5 reached by override blocks the management wake
        req_state = 3'h5;
        req_override = 1;
        POWER_MGMT_WAKE_STATUS = 1;
        wr(16'h002A, 16'h0804);
        waitn(3);
        check("s5 override wake", WAKE_EVENT, 16'h0000);
        req_override = 0;
        waitn(3);
        check("s5 wake", WAKE_EVENT, 16'h0001);
        $display("event gating test done");
        // codec data high only counts while the bit clock is idle
        CODEC_BITCLK_IDLE = 0;
        CODEC_SDATA_IN = 2'h2;
        waitn(2);
        rd(16'h0028, 16'h0000);
        CODEC_BITCLK_IDLE = 1;
        waitn(2);
        rd(16'h0028, 16'h0020);
        CODEC_SDATA_IN = 2'h0;
        wr(16'h0028, 16'hFFFF);
        rd(16'h0028, 16'h0000);
        $display("codec status test done");
        // a read that never answered would leave its note behind
        waitn(2);
        check("reads left", 16'(exp_q.size()), 16'h0000);
        final_report();
    end
endmodule : tb
`default_nettype wire
